// *** bench/ecm_encoder_model.sv ***
// Behavioural absolute position encoder at the far end of the link.
`timescale 1ns/1ps
module ecm_encoder_model (
  input wire logic         link_clk,
  input wire logic         oe_n,
  input wire logic         mosi,
  input wire logic [127:0] frame,
  input wire logic [7:0]   nbits,
  output logic             miso,
  output logic [31:0]      got,
  output logic [7:0]       ngot
);
  logic [7:0] idx = 8'h00;
  logic       tx_new = 1'b1;
  initial begin
    miso = 1'b0;
    got = 32'h0;
    ngot = 8'h00;
  end
  // Bits are taken on the rising link edge, since the master moves them on falling.
  always @(posedge link_clk) begin
    if (!oe_n) begin
      got    <= tx_new ? {31'h0, mosi} : {got[30:0], mosi};
      ngot   <= tx_new ? 8'h01 : ngot + 8'h01;
      tx_new <= 1'b0;
      idx    <= 8'h00;
      miso   <= 1'b0;
    end else begin
      tx_new <= 1'b1;
      idx    <= idx + 8'h01;
      miso   <= (idx < nbits) ? frame[nbits - 8'h01 - idx] : ~miso;
    end
  end
endmodule

// *** bench/ecm_properties.sv ***
// Port-level assertions for the encoder mode-command master.
`timescale 1ns/1ps
module ecm_properties (
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire logic                    cmd_valid,
  input wire ecm_pkg::ecm_cmd_type    cmd,
  input wire logic [6:0]              position_clocks,
  input wire logic                    busy,
  input wire logic                    cmd_ok,
  input wire logic                    cmd_err,
  input wire logic                    frame_ready_flag,
  input wire ecm_pkg::ecm_result_type result,
  input wire logic                    enc_clk,
  input wire logic                    enc_data_out,
  input wire logic                    enc_data_oe_n,
  input wire logic                    enc_data_in
);
  import ecm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ****************************************
  // Command handshake, frame end and idle link
  // ****************************************
  sequence s_take;
    cmd_valid && !busy;
  endsequence
  sequence s_start;
    busy && !frame_ready_flag && !enc_data_oe_n;
  endsequence
  property p_answer;
    s_take |=> cmd_ok ^ cmd_err;
  endproperty
  a_answer: assert property (p_answer) else $error("command not answered");
  property p_ok_cause;
    cmd_ok |-> $past(cmd_valid && !busy);
  endproperty
  a_ok_cause: assert property (p_ok_cause) else $error("answer without request");
  property p_pulse;
    (cmd_ok || cmd_err) |=> !cmd_ok && !cmd_err;
  endproperty
  a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
  property p_start;
    cmd_ok |-> s_start;
  endproperty
  a_start: assert property (p_start) else $error("frame not started on accept");
  property p_ready;
    $rose(frame_ready_flag) |-> $fell(busy);
  endproperty
  a_ready: assert property (p_ready) else $error("ready without frame end");
  property p_fall;
    $fell(busy) |-> frame_ready_flag;
  endproperty
  a_fall: assert property (p_fall) else $error("frame end without ready");
  property p_hold;
    frame_ready_flag && $past(frame_ready_flag) |-> $stable(result);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved while ready");
  property p_idle;
    !busy |-> enc_clk && enc_data_oe_n;
  endproperty
  a_idle: assert property (p_idle) else $error("link active while idle");
  property p_drive;
    $fell(enc_data_oe_n) |-> cmd_ok;
  endproperty
  a_drive: assert property (p_drive) else $error("line driven without command");
endmodule

// *** bench/encoder_mode_command_master_tb.sv ***
// Self-checking testbench of the encoder mode-command master.
`timescale 1ns/1ps
module encoder_mode_command_master_tb;
  import ecm_pkg::*;
  logic           clk = 1'b0;
  logic           nrst = 1'b0;
  logic           cmd_valid = 1'b0;
  ecm_cmd_type    cmd = '0;
  logic [6:0]     position_clocks = 7'h14;
  logic           busy, cmd_ok, cmd_err, frame_ready_flag;
  ecm_result_type result;
  logic           enc_clk, enc_data_out, enc_data_oe_n, enc_data_in, miso;
  logic [127:0]   frm = '0;
  logic [31:0]    got;
  logic [7:0]     ngot;
  logic [4:0]     crc;
  logic           fb;
  int             nf = 0;
  int             n_mismatch = 0;
  int             num_checks = 0;
  int             cyc = 0;

  always #50 clk = ~clk;
  assign enc_data_in = enc_data_oe_n ? miso : enc_data_out;

  ecm_master #(.POS_MAX(64), .START_WAIT_BITS(32)) i_ecm_master (
    .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd), .position_clocks(position_clocks),
    .busy(busy), .cmd_ok(cmd_ok), .cmd_err(cmd_err), .frame_ready_flag(frame_ready_flag),
    .result(result), .enc_clk(enc_clk), .enc_data_out(enc_data_out),
    .enc_data_oe_n(enc_data_oe_n), .enc_data_in(enc_data_in));
  ecm_encoder_model i_ecm_encoder_model (
    .link_clk(enc_clk), .oe_n(enc_data_oe_n), .mosi(enc_data_out), .frame(frm),
    .nbits(nf[7:0]), .miso(miso), .got(got), .ngot(ngot));

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ****************************************
  // Encoder answer frame: two idle bits, start bit, then checked fields
  // ****************************************
  task automatic put(input logic [63:0] v, input int w, input bit c);
    for (int i = w - 1; i >= 0; i--) begin
      frm = {frm[126:0], v[i]};
      nf++;
      fb = crc[4] ^ v[i];
      if (c) crc = {crc[3:0], 1'b0} ^ (fb ? CRC_POLY : 5'h00);
    end
  endtask
  task automatic hdr(input int nerr);
    frm = '0;
    nf = 0;
    crc = CRC_INIT;
    put(64'h1, 3, 0);
    // The last error bit is set so that the error field is seen to arrive.
    put(64'h1, nerr, 1);
  endtask
  task automatic tail(input logic [4:0] bad);
    put({59'h0, crc ^ bad}, 5, 0);
    crc = CRC_INIT;
  endtask

  task automatic issue(input logic [5:0] m, input logic [7:0] f1, input logic [15:0] f2,
                       input logic [1:0] n, input logic ok);
    logic so;
    logic se;
    so = 1'b0;
    se = 1'b0;
    @(posedge clk);
    cmd <= '{m, f1, f2, n};
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (2) begin
      #1;
      so |= cmd_ok;
      se |= cmd_err;
      @(posedge clk);
    end
    check(so, ok);
    check(se, !ok);
    if (ok) begin
      for (int i = 0; i < 3000 && frame_ready_flag !== 1'b1; i++) begin
        @(posedge clk);
        #1;
      end
      check(frame_ready_flag, 1'b1);
      check(result.timeout, 1'b0);
    end
  endtask

  task automatic param_xfer(input logic [5:0] m, input logic [7:0] f1, input logic [15:0] f2);
    hdr(0);
    put({f1, f2}, 24, 1);
    tail(5'h00);
    issue(m, f1, f2, 2'h0, 1'b1);
    check(got, {IDLE_BITS, m, f1, f2});
    check(ngot, 8'h20);
    check(result.pos_lo[23:0], {f1, f2});
    check(result.crc_ok[0], 1'b1);
  endtask

  task automatic pos_xfer(input logic [5:0] m, input logic [7:0] f1, input logic [1:0] n,
                          input int pc, input logic [63:0] v, input int nadd,
                          input logic [4:0] bad);
    hdr(m < 6'h10 ? 1 : 2);
    for (int k = 0; k < pc; k++) put({63'h0, v[k]}, 1, 1);
    tail(5'h00);
    for (int j = 0; j < nadd; j++) begin
      put(j == 0 ? 64'h5A3C96 : 64'h0F1E2D, 24, 1);
      tail(j == 1 ? bad : 5'h00);
    end
    @(posedge clk);
    position_clocks <= pc[6:0];
    issue(m, f1, 16'hA55A, n, 1'b1);
    check({result.pos_hi, result.pos_lo}, v);
    check(result.crc_ok[0], 1'b1);
    if (nadd > 0) check(result.add1, 24'h5A3C96);
    check(result.err, 2'h1);
  endtask

  task automatic t_refuse();
    issue(MODE_RD_PARAM, 8'h0D, 16'h0, 2'h0, 1'b0);
    issue(MODE_WR_PARAM, 8'hA1, 16'h5555, 2'h0, 1'b0);
    issue(MODE_TEST_VAL, 8'h00, 16'h0, 2'h0, 1'b0);
    issue(6'h3F, 8'h00, 16'h0, 2'h0, 1'b0);
    issue(MODE_POS_ADD, 8'h00, 16'h0, 2'h3, 1'b0);
  endtask

  task automatic t_params();
    param_xfer(MODE_SEL_MEM, 8'hA1, 16'h5555);
    param_xfer(MODE_RD_PARAM, 8'h0D, 16'h1234);
    param_xfer(MODE_WR_PARAM, 8'hA1, 16'h5555);
    param_xfer(MODE_RD_PARAM, 8'h00, 16'h0003);
    param_xfer(MODE_COMM, 8'h03, 16'h00C1);
    param_xfer(MODE_RESET, 8'hA1, 16'h5555);
    issue(MODE_RD_PARAM, 8'h0D, 16'h0, 2'h0, 1'b0);
  endtask

  task automatic t_test();
    param_xfer(MODE_TEST_CMD, 8'h07, 16'h0);
    hdr(1);
    put(64'hA712345678, 40, 1);
    tail(5'h00);
    issue(MODE_TEST_VAL, 8'h00, 16'h0, 2'h0, 1'b1);
    check(result.pos_hi[7:0], 8'hA7);
    check(result.pos_lo, 32'h12345678);
    check(ngot, 8'h08);
  endtask

  task automatic t_position();
    pos_xfer(MODE_POS, 8'h00, 2'h2, 20, 64'h95A3C, 0, 5'h00);
    check(got[7:0], {IDLE_BITS, MODE_POS});
    pos_xfer(MODE_POS, 8'h00, 2'h0, 64, 64'hC3A50F961E2D874B, 0, 5'h00);
    pos_xfer(MODE_POS_ADD, 8'h00, 2'h2, 40, 64'hB713579BDF, 2, 5'h04);
    check(result.add2, 24'h0F1E2D);
    check(result.crc_ok, 3'h3);
  endtask

  task automatic t_combined();
    logic [5:0] m;
    for (int i = 0; i < 5; i++) begin
      m = MODE_POS_SEL + 6'(i);
      pos_xfer(m, 8'h40 + 8'(i), 2'h1, 16, 64'h6C3 + 64'(i), 1, 5'h00);
      check(got, {IDLE_BITS, m, 8'h40 + 8'(i), 16'hA55A});
    end
  endtask

  // A silent encoder must still end the frame, with the timeout bit set.
  task automatic t_timeout();
    frm = '0;
    nf = 40;
    @(posedge clk);
    cmd <= '{MODE_POS, 8'h00, 16'h0000, 2'h0};
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 3000 && frame_ready_flag !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check(frame_ready_flag, 1'b1);
    check(result.timeout, 1'b1);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_refuse();
    t_params();
    t_test();
    t_position();
    t_combined();
    t_timeout();
    conclude();
  end
endmodule

bind ecm_master ecm_properties i_ecm_properties (
  .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd), .position_clocks(position_clocks),
  .busy(busy), .cmd_ok(cmd_ok), .cmd_err(cmd_err), .frame_ready_flag(frame_ready_flag),
  .result(result), .enc_clk(enc_clk), .enc_data_out(enc_data_out),
  .enc_data_oe_n(enc_data_oe_n), .enc_data_in(enc_data_in));

// *** rtl/ecm_master.sv ***
// Mode-command master for a clocked serial absolute position encoder link.
// Notes on behaviour
// - Parameter read or write is refused until a memory area select was issued.
// - Memory area select carries the range code; encoder acknowledges it.
// - Plain position request returns position only, sends no fields.
// - A test value is refused unless a test command was issued since the last accepted test value.
// - Extended commands take zero, one or two additional words.
// - Older commands always use zero additional words.
// - Combined command: position plus memory area or block select.
// - Combined command: position plus parameter write.
// - Combined command: position plus read-access parameters.
// - Combined command: position plus test command with port address.
// - Combined command: position plus error clear, fields don't-care.
// - Position field length comes from a programmable clock count.
// - Position is delivered in normal order, right-justified, two halves.
// - Received frame is unpacked per the command that started it.
// - Unknown mode flags an error; valid commands signal success.
// - Each received portion carries a 5-bit check value, recomputed here.
`timescale 1ns/1ps
module ecm_master #(
  parameter int POS_MAX         = 64,
  parameter int START_WAIT_BITS = 32
) (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    cmd_valid,
  input  wire ecm_pkg::ecm_cmd_type    cmd,
  input  wire logic [6:0]              position_clocks,
  output logic                         busy,
  output logic                         cmd_ok,
  output logic                         cmd_err,
  output logic                         frame_ready_flag,
  output ecm_pkg::ecm_result_type      result,
  output logic                         enc_clk,
  output logic                         enc_data_out,
  output logic                         enc_data_oe_n,
  input  wire logic                    enc_data_in
);
  import ecm_pkg::*;

  if (POS_MAX < 1 || POS_MAX > BODY_W) begin : g_bad_pos
    $error("POS_MAX out of range");
  end
  if (START_WAIT_BITS < 1 || START_WAIT_BITS > 255) begin : g_bad_wait
    $error("START_WAIT_BITS out of range");
  end
  if (LINK_HALF_CYC < 1) begin : g_bad_div
    $error("Link clock too fast for system clock");
  end

  // ******************************************************************
  // Reset release and input synchroniser
  // ******************************************************************
  logic rst_meta_r, rst_n_r, din_meta_r, din_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      din_meta_r <= 1'b0;
      din_r      <= 1'b0;
    end else begin
      din_meta_r <= enc_data_in;
      din_r      <= din_meta_r;
    end
  end

  // ******************************************************************
  // Command decode
  // ******************************************************************
  ecm_state_type state_r, state_nxt;
  logic mem_sel_r, test_arm_r;
  wire m_sel  = cmd.mode == MODE_SEL_MEM;
  wire m_rd   = cmd.mode == MODE_RD_PARAM;
  wire m_wr   = cmd.mode == MODE_WR_PARAM;
  wire m_rst  = cmd.mode == MODE_RESET;
  wire m_pos  = cmd.mode == MODE_POS;
  wire m_tcmd = cmd.mode == MODE_TEST_CMD;
  wire m_tval = cmd.mode == MODE_TEST_VAL;
  wire m_comm = cmd.mode == MODE_COMM;
  wire m_padd = cmd.mode == MODE_POS_ADD;
  wire m_psel = cmd.mode == MODE_POS_SEL;
  wire m_pwr  = cmd.mode == MODE_POS_WR;
  wire m_prd  = cmd.mode == MODE_POS_RD;
  wire m_ptst = cmd.mode == MODE_POS_TEST;
  wire m_pclr = cmd.mode == MODE_POS_CLR;
  wire is_old = m_sel | m_rd | m_wr | m_rst | m_pos | m_tcmd | m_tval | m_comm;
  wire is_new = m_padd | m_psel | m_pwr | m_prd | m_ptst | m_pclr;
  wire no_fields = m_pos | m_tval | m_padd;
  wire pos_kind  = m_pos | is_new;
  wire count_bad = is_new & (cmd.additional_word_count > MAX_ADD_WORDS);
  wire seq_bad = ((m_rd | m_wr | m_prd | m_pwr) & ~mem_sel_r) | (m_tval & ~test_arm_r);
  wire accept  = cmd_valid & (state_r == ST_IDLE);
  wire start   = accept & (is_old | is_new) & ~count_bad & ~seq_bad;
  wire [1:0] add_sel = is_new ? cmd.additional_word_count : 2'h0;
  wire [1:0] errn_sel = is_new ? ERR_NEW : ((m_pos | m_tval) ? ERR_OLD : 2'h0);
  wire [6:0] blen_sel = pos_kind ? position_clocks : (m_tval ? TEST_LEN : PARAM_LEN);
  // range code and fields follow the mode
  wire [31:0] tx_load = no_fields ? {IDLE_BITS, cmd.mode, 24'h000000}
                                  : {IDLE_BITS, cmd.mode, cmd.field1, cmd.field2};

  // ******************************************************************
  // Link clock divider
  // ******************************************************************
  logic [7:0] div_r;
  logic       lclk_r;
  wire running = (state_r == ST_TX) | (state_r == ST_WAIT) | (state_r == ST_RX);
  wire tick    = running & (div_r == 8'h00);
  // Data changes and is sampled at falling link edges, leaving the
  // encoder's rising-edge output a half period, less the sync delay, to settle.
  wire fall    = tick & lclk_r;
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      div_r  <= DIV_RELOAD;
      lclk_r <= 1'b1;
    end else begin
      div_r  <= (!running | tick) ? DIV_RELOAD : div_r - 8'h01;
      lclk_r <= !running ? 1'b1 : (tick ? ~lclk_r : lclk_r);
    end
  end

  // ******************************************************************
  // Frame sequencing
  // ******************************************************************
  logic [31:0] tx_sh_r;
  logic [5:0]  tx_cnt_r, tx_len_r;
  logic [7:0]  wait_cnt_r;
  logic [6:0]  bit_cnt_r, blen_r;
  logic [1:0]  seg_r, word_r, add_r, errn_r;
  logic        pos_kind_r, timeout_r;
  wire [6:0] seg_len = (seg_r == SEG_ERR) ? {5'h00, errn_r} :
                       (seg_r == SEG_CRC) ? CRC_LEN :
                       (word_r == 2'h0)   ? blen_r : ADD_LEN;
  wire seg_last  = bit_cnt_r == (seg_len - 7'h01);
  wire rx_bit    = (state_r == ST_RX) & fall;
  wire tx_end    = tx_cnt_r == tx_len_r;
  wire wait_end  = wait_cnt_r == START_WAIT_BITS[7:0];
  wire frame_end = rx_bit & (seg_r == SEG_CRC) & seg_last & (word_r == add_r);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (start) state_nxt = ST_TX;
      ST_TX:   if (fall & tx_end) state_nxt = ST_WAIT;
      ST_WAIT: begin
        if (fall & din_r) state_nxt = ST_RX;
        else if (fall & wait_end) state_nxt = ST_DONE;
      end
      ST_RX:   if (frame_end) state_nxt = ST_DONE;
      ST_DONE: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_IDLE;
      busy    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy    <= state_nxt != ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cmd_ok     <= 1'b0;
      cmd_err    <= 1'b0;
      mem_sel_r  <= 1'b0;
      test_arm_r <= 1'b0;
    end else begin
      cmd_ok  <= start;
      cmd_err <= accept & ~start;
      // remember prerequisites; encoder reset forgets them
      if (start) begin
        mem_sel_r  <= ~m_rst & (mem_sel_r | m_sel | m_psel);
        test_arm_r <= ~m_rst & ~m_tval & (test_arm_r | m_tcmd | m_ptst);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tx_sh_r       <= 32'h00000000;
      tx_cnt_r      <= 6'h00;
      tx_len_r      <= TX_SHORT;
      enc_data_out  <= 1'b0;
      enc_data_oe_n <= 1'b1;
      wait_cnt_r    <= 8'h00;
      timeout_r     <= 1'b0;
    end else if (start) begin
      tx_sh_r       <= tx_load;
      tx_cnt_r      <= 6'h00;
      tx_len_r      <= no_fields ? TX_SHORT : TX_LONG;
      enc_data_oe_n <= 1'b0;
      wait_cnt_r    <= 8'h00;
      timeout_r     <= 1'b0;
    end else if (fall & (state_r == ST_TX)) begin
      if (tx_end) begin
        enc_data_oe_n <= 1'b1;
        enc_data_out  <= 1'b0;
      end else begin
        enc_data_out <= tx_sh_r[31];
        tx_sh_r      <= {tx_sh_r[30:0], 1'b0};
        tx_cnt_r     <= tx_cnt_r + 6'h01;
      end
    end else if (fall & (state_r == ST_WAIT) & ~din_r) begin
      wait_cnt_r <= wait_cnt_r + 8'h01;
      timeout_r  <= wait_end;
    end
  end

  // ******************************************************************
  // Receive unpacking
  // ******************************************************************
  logic [BODY_W-1:0] body_r;
  logic [23:0]       add_sh_r, add1_r, add2_r;
  logic [4:0]        crc_r, crc_rx_r;
  logic [2:0]        crc_ok_r;
  logic [1:0]        err_r;
  wire [4:0] crc_step = {crc_r[3:0], 1'b0} ^ ((crc_r[4] ^ din_r) ? CRC_POLY : 5'h00);
  wire [4:0] crc_got  = {crc_rx_r[3:0], din_r};
  // LSB-first bit k lands at index k: normal order, right-justified
  wire [BODY_W-1:0] body_pos = din_r ? (body_r | ({{(BODY_W-1){1'b0}}, 1'b1} << bit_cnt_r))
                                     : body_r;
  wire [BODY_W-1:0] body_nxt = pos_kind_r ? body_pos : {body_r[BODY_W-2:0], din_r};

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      bit_cnt_r  <= 7'h00;
      seg_r      <= SEG_BODY;
      word_r     <= 2'h0;
      add_r      <= 2'h0;
      errn_r     <= 2'h0;
      blen_r     <= PARAM_LEN;
      pos_kind_r <= 1'b0;
    end else if (start) begin
      bit_cnt_r  <= 7'h00;
      seg_r      <= (errn_sel != 2'h0) ? SEG_ERR : SEG_BODY;
      word_r     <= 2'h0;
      add_r      <= add_sel;
      errn_r     <= errn_sel;
      blen_r     <= blen_sel;
      pos_kind_r <= pos_kind;
    end else if (rx_bit) begin
      bit_cnt_r <= seg_last ? 7'h00 : bit_cnt_r + 7'h01;
      if (seg_last) begin
        seg_r <= (seg_r == SEG_BODY) ? SEG_CRC : SEG_BODY;
        if (seg_r == SEG_CRC) word_r <= word_r + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      body_r   <= '0;
      add_sh_r <= 24'h000000;
      add1_r   <= 24'h000000;
      add2_r   <= 24'h000000;
      crc_r    <= CRC_INIT;
      crc_rx_r <= 5'h00;
      crc_ok_r <= 3'h0;
      err_r    <= 2'h0;
    end else if (start) begin
      body_r   <= '0;
      crc_r    <= CRC_INIT;
      crc_ok_r <= 3'h0;
      err_r    <= 2'h0;
      add1_r   <= 24'h000000;
      add2_r   <= 24'h000000;
    end else if (rx_bit) begin
      if (seg_r == SEG_CRC) begin
        crc_rx_r <= crc_got;
        if (seg_last) begin
          crc_ok_r[word_r] <= crc_got == crc_r;
          crc_r            <= CRC_INIT;
          if (word_r == 2'h1) add1_r <= add_sh_r;
          if (word_r == 2'h2) add2_r <= add_sh_r;
        end
      end else begin
        crc_r <= crc_step;
        if (seg_r == SEG_ERR) err_r <= {err_r[0], din_r};
        else if (word_r == 2'h0) body_r <= body_nxt;
        else add_sh_r <= {add_sh_r[22:0], din_r};
      end
    end
  end

  // ******************************************************************
  // Result delivery
  // ******************************************************************
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      result           <= '0;
      frame_ready_flag <= 1'b0;
    end else if (start) begin
      frame_ready_flag <= 1'b0;
    end else if (state_r == ST_DONE) begin
      frame_ready_flag <= 1'b1;
      result           <= {body_r[63:32], body_r[31:0], add1_r, add2_r,
                           err_r, crc_ok_r, timeout_r};
    end
  end

  assign enc_clk = lclk_r;
endmodule

// *** rtl/ecm_pkg.sv ***
// Constants, mode codes and carrier types of the encoder mode-command master.
package ecm_pkg;
  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int LINK_PERIOD_NS = 800;
  // A half link period is a longest time, so it rounds down.
  localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [7:0] DIV_RELOAD = 8'(LINK_HALF_CYC - 1);

  // ******************************************************************
  // Mode codes (values are arbitrary)
  // ******************************************************************
  localparam logic [5:0] MODE_SEL_MEM  = 6'h01;
  localparam logic [5:0] MODE_RD_PARAM = 6'h02;
  localparam logic [5:0] MODE_WR_PARAM = 6'h03;
  localparam logic [5:0] MODE_RESET    = 6'h04;
  localparam logic [5:0] MODE_POS      = 6'h05;
  localparam logic [5:0] MODE_TEST_CMD = 6'h06;
  localparam logic [5:0] MODE_TEST_VAL = 6'h07;
  localparam logic [5:0] MODE_COMM     = 6'h08;
  localparam logic [5:0] MODE_POS_ADD  = 6'h11;
  localparam logic [5:0] MODE_POS_SEL  = 6'h12;
  localparam logic [5:0] MODE_POS_WR   = 6'h13;
  localparam logic [5:0] MODE_POS_RD   = 6'h14;
  localparam logic [5:0] MODE_POS_TEST = 6'h15;
  localparam logic [5:0] MODE_POS_CLR  = 6'h16;

  // ******************************************************************
  // Frame layout
  // ******************************************************************
  localparam int         BODY_W        = 64;
  localparam logic [5:0] TX_SHORT      = 6'h08;
  localparam logic [5:0] TX_LONG       = 6'h20;
  localparam logic [1:0] IDLE_BITS     = 2'h0;
  localparam logic [1:0] ERR_OLD       = 2'h1;
  localparam logic [1:0] ERR_NEW       = 2'h2;
  localparam logic [1:0] MAX_ADD_WORDS = 2'h2;
  localparam logic [6:0] TEST_LEN      = 7'h28;
  localparam logic [6:0] PARAM_LEN     = 7'h18;
  localparam logic [6:0] ADD_LEN       = 7'h18;
  localparam logic [6:0] CRC_LEN       = 7'h05;
  localparam logic [4:0] CRC_POLY      = 5'h0B;
  localparam logic [4:0] CRC_INIT      = 5'h1F;
  localparam logic [1:0] SEG_ERR       = 2'h0;
  localparam logic [1:0] SEG_BODY      = 2'h1;
  localparam logic [1:0] SEG_CRC       = 2'h2;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_TX   = 5'h02,
    ST_WAIT = 5'h04,
    ST_RX   = 5'h08,
    ST_DONE = 5'h10
  } ecm_state_type;

  typedef struct packed {
    logic [5:0]  mode;
    logic [7:0]  field1;
    logic [15:0] field2;
    logic [1:0]  additional_word_count;
  } ecm_cmd_type;

  typedef struct packed {
    logic [31:0] pos_hi;
    logic [31:0] pos_lo;
    logic [23:0] add1;
    logic [23:0] add2;
    logic [1:0]  err;
    logic [2:0]  crc_ok;
    logic        timeout;
  } ecm_result_type;
endpackage
